// File: hw/irq_serial_pkg.sv
// constants for the interrupt recognition and serial bit unit
// assumes a single 250 MHz clock and an Avalon-MM register master
`default_nettype none

package irq_serial_pkg;

  // ==========================================================
  // clocking
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned MIN_OSC_HZ  = 1_000_000;     // least oscillator rate
  localparam int unsigned DIV_RATIO   = 2;             // internal clock = osc / 2
  localparam int unsigned CPU_HZ      = CLK_HZ / DIV_RATIO;

  // ==========================================================
  // register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;   // enable control
  localparam logic [3:0] ADDR_SMI  = 4'h4;   // set-mask instruction
  localparam logic [3:0] ADDR_RMI  = 4'h8;   // read-mask instruction
  localparam logic [3:0] ADDR_SVC  = 4'hC;   // service / acknowledge

  // control register bits
  localparam int CTRL_IRQ_ON = 0;   // write 1: enable interrupts
  localparam int CTRL_DI  = 1;   // write 1: disable interrupts
  localparam int CTRL_HLD = 1;   // read: synchronised hold request

  // set-mask data bits
  localparam int SM_M55  = 0;
  localparam int SM_M65  = 1;
  localparam int SM_M75  = 2;
  localparam int SM_MSE  = 3;
  localparam int SM_R75  = 4;
  localparam int SM_SOE  = 6;
  localparam int SM_SERIAL_OUT = 7;

  // mask state after reset: all restarts masked
  localparam logic [2:0] MASK_RST = 3'h7;

  // read-mask data bits
  localparam int RM_IE   = 3;
  localparam int RM_P55  = 4;
  localparam int RM_P65  = 5;
  localparam int RM_P75  = 6;
  localparam int RM_SERIAL_IN = 7;

  // service register fields
  localparam int SV_PEND = 7;
  localparam int SV_VLO  = 8;

  // ==========================================================
  // request sources, index into the request vector
  localparam int SRC_GEN  = 0;
  localparam int SRC_55   = 1;
  localparam int SRC_65   = 2;
  localparam int SRC_75   = 3;
  localparam int SRC_TRAP = 4;
  localparam int NSRC     = 5;

  // restart vectors
  localparam logic [7:0] VEC_TRAP = 8'h24;
  localparam logic [7:0] VEC_75   = 8'h3C;
  localparam logic [7:0] VEC_65   = 8'h34;
  localparam logic [7:0] VEC_55   = 8'h2C;
  localparam logic [7:0] VEC_GEN  = 8'h00;   // supplied by external logic

  // bus answer state
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

endpackage : irq_serial_pkg

`default_nettype wire

// File: hw/irq_serial_unit.sv
// interrupt recognition, masking and one-bit serial port of an 8-bit cpu
// assumes the core acts as Avalon-MM master; request pins are asynchronous
`timescale 1ns/1ns
`default_nettype none

// Function
// - five request inputs: trap, three restarts, general
// - restart lines masked each; trap unmasked
// - maskable serviced only when enabled and unmasked
// - trap serviced regardless of enable and masks
// - 5.5 and 6.5 are level, high, sampled
// - 7.5 rising edge latches until serviced
// - 7.5 latch cleared by set-mask or reset
// - 7.5 latch captures edges while masked
// - fixed priority trap, 7.5, 6.5, 5.5, general
// - priority ignores routine currently in service
// - trap needs low then high again
// - any entry clears global enable
// - trap saves enable; first read-mask reports it
// - other entries read live, disabled enable
// - read-mask samples input; set-mask drives output
// - hold and requests synchronised to internal clock
// - internal clock is oscillator divided by two
// - fixed restart vectors for trap and restarts
// - general line vector comes from acknowledge cycle
// - serial input lands in read-mask bit seven
module irq_serial_unit
  import irq_serial_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // request pins
  input  wire logic        trap_req_i,
  input  wire logic        rst75_req_i,
  input  wire logic        rst65_req_i,
  input  wire logic        rst55_req_i,
  input  wire logic        general_request_line_i,
  input  wire logic        hold_req_i,
  input  wire logic        serial_input_line_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // core side
  output logic             cpu_clk_en_o,
  output logic             irq_pending_o,
  output logic             request_acknowledge_strobe_o,
  output logic             serial_output_line_o
);

  // ==========================================================
  // internal clock divider
  logic div_q;

  // halve the rate; one enable pulse per internal clock
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      div_q <= 1'b0;
    else
      div_q <= ~div_q;

  assign cpu_clk_en_o = div_q;

  // ==========================================================
  // input synchronisers
  logic [6:0] pin_raw;
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] sync3;
  logic [6:0] stable;
  logic [6:0] agree;

  assign pin_raw = {serial_input_line_i, hold_req_i, trap_req_i, rst75_req_i,
                    rst65_req_i, rst55_req_i, general_request_line_i};
  assign agree   = ~(sync2 ^ sync3);

  // three stages; a change is taken once stages two and three agree
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      sync1  <= 7'h00;
      sync2  <= 7'h00;
      sync3  <= 7'h00;
      stable <= 7'h00;
    end
    else if (div_q)
    begin
      sync1  <= pin_raw;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= (stable & ~agree) | (sync3 & agree);
    end

  logic gen_lvl, l55, l65, l75, trap_lvl, hold_lvl, ser_in_lvl;
  assign {ser_in_lvl, hold_lvl, trap_lvl, l75, l65, l55, gen_lvl} = stable;

  // ==========================================================
  // bus decode
  bus_state_t bus_state;
  logic       req;
  logic       acc;
  logic       wr_ctrl, wr_smi, wr_svc, rd_rmi;

  assign req     = avs_read_i | avs_write_i;
  assign acc     = req & (bus_state == BUS_ANSWER);
  assign wr_ctrl = acc & avs_write_i & (avs_address_i == ADDR_CTRL);
  assign wr_smi  = acc & avs_write_i & (avs_address_i == ADDR_SMI);
  assign wr_svc  = acc & avs_write_i & (avs_address_i == ADDR_SVC);
  assign rd_rmi  = acc & avs_read_i  & (avs_address_i == ADDR_RMI);

  // ==========================================================
  // mask, enable and latch state
  logic [2:0] mask;      // {7.5, 6.5, 5.5}
  logic       ie;
  logic       ff75;
  logic       l75_d;
  logic       trap_armed;
  logic       trap_saved_vld;
  logic       trap_saved_ie;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] win;
  logic       svc_go;

  // highest pending source wins; one-hot result
  function automatic logic [NSRC-1:0] pick(input logic [NSRC-1:0] p);
    logic [NSRC-1:0] r;
    r = '0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (p[i] && r == '0)
        r[i] = 1'b1;
    return r;
  endfunction : pick

  // restart vector of the winning source
  function automatic logic [7:0] vec_of(input logic [NSRC-1:0] w);
    logic [7:0] v;
    v = VEC_GEN;
    if (w[SRC_TRAP])    v = VEC_TRAP;
    else if (w[SRC_75]) v = VEC_75;
    else if (w[SRC_65]) v = VEC_65;
    else if (w[SRC_55]) v = VEC_55;
    return v;
  endfunction : vec_of

  // trap is unmasked; restarts need enable and clear mask
  assign pend[SRC_TRAP] = trap_lvl & trap_armed;
  assign pend[SRC_75]   = ie & ~mask[2] & ff75;
  assign pend[SRC_65]   = ie & ~mask[1] & l65;
  assign pend[SRC_55]   = ie & ~mask[0] & l55;
  assign pend[SRC_GEN]  = ie & gen_lvl;
  assign win            = pick(pend);
  assign svc_go         = wr_svc & (pend != '0);

  // masks change only with the mask-set enable bit
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      mask <= MASK_RST;
    else if (wr_smi && avs_writedata_i[SM_MSE])
      mask <= avs_writedata_i[SM_M75:SM_M55];

  // global enable: entry clears, enable instruction sets
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      ie <= 1'b0;
    else if (svc_go)
      ie <= 1'b0;
    else if (wr_ctrl && avs_writedata_i[CTRL_IRQ_ON])
      ie <= 1'b1;
    else if (wr_ctrl && avs_writedata_i[CTRL_DI])
      ie <= 1'b0;

  // 7.5 edge latch; a new edge wins over any clear
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      l75_d <= 1'b0;
      ff75  <= 1'b0;
    end
    else
    begin
      l75_d <= l75;
      if (l75 && !l75_d)
        ff75 <= 1'b1;
      else if ((svc_go && win[SRC_75]) || (wr_smi && avs_writedata_i[SM_R75]))
        ff75 <= 1'b0;
    end

  // trap arms on a low level, disarms when serviced
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      trap_armed <= 1'b0;
    else if (!trap_lvl)
      trap_armed <= 1'b1;
    else if (svc_go && win[SRC_TRAP])
      trap_armed <= 1'b0;

  // enable saved at trap entry, reported by the next read-mask only
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      trap_saved_vld <= 1'b0;
      trap_saved_ie  <= 1'b0;
    end
    else if (svc_go && win[SRC_TRAP])
    begin
      trap_saved_vld <= 1'b1;
      trap_saved_ie  <= ie;
    end
    else if (rd_rmi || svc_go)
      trap_saved_vld <= 1'b0;

  // serial output updated only with its enable bit
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      serial_output_line_o <= 1'b0;
    else if (wr_smi && avs_writedata_i[SM_SOE])
      serial_output_line_o <= avs_writedata_i[SM_SERIAL_OUT];

  // pending flag for any source and acknowledge strobe for the general line
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      irq_pending_o                <= 1'b0;
      request_acknowledge_strobe_o <= 1'b0;
    end
    else
    begin
      irq_pending_o                <= (pend != '0);
      request_acknowledge_strobe_o <= svc_go & win[SRC_GEN];
    end

  // ==========================================================
  // avalon answer: waitrequest low one cycle after the request
  logic [31:0] next_rdata;

  // read data mux
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i)
      ADDR_CTRL:
      begin
        next_rdata[CTRL_IRQ_ON] = ie;
        next_rdata[CTRL_HLD]    = hold_lvl;
      end
      ADDR_RMI:
      begin
        next_rdata[SM_M75:SM_M55] = mask;
        next_rdata[RM_IE]  = trap_saved_vld ? trap_saved_ie : ie;
        next_rdata[RM_P55] = l55;
        next_rdata[RM_P65] = l65;
        next_rdata[RM_P75] = ff75;
        next_rdata[RM_SERIAL_IN] = ser_in_lvl;
      end
      ADDR_SVC:
      begin
        next_rdata[NSRC-1:0]           = win;
        next_rdata[SV_PEND]            = (pend != '0);
        next_rdata[SV_VLO +: 8]        = vec_of(win);
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // bus state and registered answer
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      bus_state         <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else
      case (bus_state)
        BUS_IDLE:
          if (req)
          begin
            bus_state         <= BUS_ANSWER;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= avs_read_i ? next_rdata : 32'h0000_0000;
          end
        BUS_ANSWER:
        begin
          bus_state         <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default:
        begin
          bus_state         <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_seen;
    req && avs_waitrequest_o && bus_state == BUS_IDLE;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  property p_bus_answer;
    s_req_seen |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_trap_unmasked;
    (trap_lvl && trap_armed) |=> irq_pending_o;
  endproperty
  a_trap_unmasked: assert property (p_trap_unmasked) else $error("trap lost");

  property p_masked_55;
    (!ie || mask[0]) |-> !win[SRC_55];
  endproperty
  a_masked_55: assert property (p_masked_55) else $error("5.5 passed mask");

  property p_entry_clears_ie;
    svc_go |=> !ie;
  endproperty
  a_entry_clears_ie: assert property (p_entry_clears_ie) else $error("ie kept");

  property p_edge75;
    (l75 && !l75_d) |=> ff75;
  endproperty
  a_edge75: assert property (p_edge75) else $error("7.5 edge missed");

  sequence s_trap_entry;
    svc_go && win[SRC_TRAP];
  endsequence

  // after service the line must fall and rise again before it counts
  property p_trap_rearm;
    s_trap_entry |=> !pend[SRC_TRAP] [*2];
  endproperty
  a_trap_rearm: assert property (p_trap_rearm) else $error("trap retaken");

  property p_trap_save_ie;
    s_trap_entry |=> trap_saved_vld && trap_saved_ie == $past(ie);
  endproperty
  a_trap_save_ie: assert property (p_trap_save_ie) else $error("enable not saved");

  // first read-mask after trap entry answers with the saved enable
  property p_trap_saves;
    (req && avs_waitrequest_o && bus_state == BUS_IDLE && avs_read_i &&
     avs_address_i == ADDR_RMI && trap_saved_vld) |=>
      avs_readdata_o[RM_IE] == trap_saved_ie;
  endproperty
  a_trap_saves: assert property (p_trap_saves) else $error("saved ie lost");

  property p_sod;
    (wr_smi && avs_writedata_i[SM_SOE]) |=>
      serial_output_line_o == $past(avs_writedata_i[SM_SERIAL_OUT]);
  endproperty
  a_sod: assert property (p_sod) else $error("serial out wrong");

  property p_trap_first;
    pend[SRC_TRAP] |-> win == (5'h01 << SRC_TRAP) && vec_of(win) == VEC_TRAP;
  endproperty
  a_trap_first: assert property (p_trap_first) else $error("priority wrong");

endmodule : irq_serial_unit

`default_nettype wire

// File: tb/irq_requester.sv
// model of the peripheral logic that raises the five interrupt request pins
// assumes the bench commands it on the rising clock edge; no buffering
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// request pin driver
module irq_requester
(
  // clock, reset and bench commands
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] level_i,
  input  wire logic       trap_go_i,
  input  wire logic       trap_ack_i,
  // request pins
  output logic            trap_o,
  output logic [3:0]      lines_o
);
  // trap stays high from the request until the bench acknowledges it
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      trap_o <= 1'b0;
    else if (trap_go_i)
      trap_o <= 1'b1;
    else if (trap_ack_i)
      trap_o <= 1'b0;
  end

  // bit 0 general, 1 rst 5.5, 2 rst 6.5, 3 rst 7.5 (pulse given by the bench)
  assign lines_o = level_i;
endmodule : irq_requester

`default_nettype wire

// File: tb/cpu_interrupt_and_serial_bit_unit_tb.sv
// self-checking bench for the interrupt recognition and serial bit unit
// assumes one 250 MHz clock and the register map of the design package
`timescale 1ns/1ns
`default_nettype none

module cpu_interrupt_and_serial_bit_unit_tb;
  import irq_serial_pkg::*;
  // ==========================================================
  // signals
  logic        mclk_i, rst_i, hold_req_i, serial_input_line_i, tgo, tack;
  logic        trap_req_i, rst75_req_i, rst65_req_i, rst55_req_i, general_request_line_i;
  logic        avs_read_i, avs_write_i, avs_waitrequest_o, cpu_clk_en_o, irq_pending_o;
  logic        request_acknowledge_strobe_o, serial_output_line_o, c0;
  logic [3:0]  avs_address_i, lv, lines;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  int          n_errors, tests_run, n_ack;
  logic [15:0] exp_svc [3];

  // design and request logic model
  irq_serial_unit DUT (.mclk_i, .rst_i, .trap_req_i, .rst75_req_i, .rst65_req_i,
    .rst55_req_i, .general_request_line_i, .hold_req_i, .serial_input_line_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
    .avs_waitrequest_o, .cpu_clk_en_o, .irq_pending_o, .request_acknowledge_strobe_o,
    .serial_output_line_o);
  irq_requester peer (.mclk_i, .rst_i, .level_i(lv), .trap_go_i(tgo),
    .trap_ack_i(tack), .trap_o(trap_req_i), .lines_o(lines));
  assign {rst75_req_i, rst65_req_i, rst55_req_i, general_request_line_i} = lines;

  // clock and acknowledge strobe counter
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  always @(negedge mclk_i)
    if (request_acknowledge_strobe_o === 1'b1)
      n_ack++;

  // ==========================================================
  // tasks
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one bus access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    // values read just after the edge are those the edge sampled
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 64);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 64)
    begin
      n_errors++;
      $display("Error at %0t: bus answer timed out", $time);
      stop_test();
    end
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  // pins cross the synchronisers in under 16 cycles
  task automatic settle();
    repeat (16) @(posedge mclk_i);
  endtask : settle

  // 0: 7.5 line, 1: trap request, else trap acknowledge; held long enough
  // for the three-stage filter, which drops anything under two enables
  task automatic pulse(input int unsigned sel);
    @(posedge mclk_i);
    case (sel)
      0: lv[3] <= 1'b1;
      1: tgo <= 1'b1;
      default: tack <= 1'b1;
    endcase
    repeat (8) @(posedge mclk_i);
    lv[3] <= 1'b0;
    tgo   <= 1'b0;
    tack  <= 1'b0;
    settle();
  endtask : pulse

  // ==========================================================
  // main sequence
  initial
  begin
    rst_i = 1'b1;
    {hold_req_i, serial_input_line_i, tgo, tack, avs_read_i, avs_write_i} = '0;
    lv = 4'h0;
    avs_address_i = 4'h0;
    avs_writedata_i = 32'h0;
    {n_errors, tests_run, n_ack} = '0;
    exp_svc = '{{VEC_65, 8'h84}, {VEC_55, 8'h82}, {VEC_GEN, 8'h81}};
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    settle();
    rd(ADDR_RMI, 32'h07);
    rd(ADDR_SVC, 32'h0);
    rd(4'h2, 32'h0);
    @(negedge mclk_i);
    c0 = cpu_clk_en_o;
    @(negedge mclk_i);
    check({31'h0, cpu_clk_en_o}, {31'h0, ~c0});
    @(posedge mclk_i);
    hold_req_i <= 1'b1;
    serial_input_line_i <= 1'b1;
    settle();
    rd(ADDR_CTRL, 32'h2);
    rd(ADDR_RMI, 32'h87);
    bus(1'b1, ADDR_SMI, 32'hC0);
    bus(1'b1, ADDR_SMI, 32'h00);
    @(negedge mclk_i);
    check({31'h0, serial_output_line_o}, 32'h1);
    bus(1'b1, ADDR_SMI, 32'h40);
    @(negedge mclk_i);
    check({31'h0, serial_output_line_o}, 32'h0);
    rd(ADDR_RMI, 32'h87);
    hold_req_i <= 1'b0;
    serial_input_line_i <= 1'b0;
    $display("test serial and reset state done");
    // 7.5 edge caught while masked, then cleared by set-mask
    pulse(0);
    rd(ADDR_RMI, 32'h47);
    bus(1'b1, ADDR_SMI, 32'h10);
    rd(ADDR_RMI, 32'h07);
    $display("test edge latch done");
    // all maskable lines at once, served in priority order
    bus(1'b1, ADDR_SMI, 32'h08);
    bus(1'b1, ADDR_CTRL, 32'h1);
    lv[2:0] <= 3'b111;
    pulse(0);
    check({31'h0, irq_pending_o}, 32'h1);
    rd(ADDR_SVC, {16'h0, VEC_75, 8'h88});
    bus(1'b1, ADDR_SVC, 32'h0);
    rd(ADDR_RMI, 32'h30);
    for (int k = 0; k < 3; k++)
    begin
      bus(1'b1, ADDR_CTRL, 32'h1);
      rd(ADDR_SVC, {16'h0, exp_svc[k]});
      bus(1'b1, ADDR_SVC, 32'h0);
      lv[2 - k] <= 1'b0;
      settle();
    end
    check(n_ack, 32'h1);
    $display("test priority done");
    // enable and mask both gate a level request
    lv[1] <= 1'b1;
    settle();
    check({31'h0, irq_pending_o}, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    bus(1'b1, ADDR_SMI, 32'h09);
    settle();
    check({31'h0, irq_pending_o}, 32'h0);
    bus(1'b1, ADDR_SMI, 32'h08);
    settle();
    check({31'h0, irq_pending_o}, 32'h1);
    lv[1] <= 1'b0;
    bus(1'b1, ADDR_SMI, 32'h0F);
    bus(1'b1, ADDR_CTRL, 32'h2);
    rd(ADDR_CTRL, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h1);
    rd(ADDR_CTRL, 32'h1);
    $display("test gating done");
    // trap ignores masks, saves enable, needs a new rising edge
    pulse(1);
    rd(ADDR_SVC, {16'h0, VEC_TRAP, 8'h90});
    bus(1'b1, ADDR_SVC, 32'h0);
    settle();
    check({31'h0, irq_pending_o}, 32'h0);
    rd(ADDR_RMI, 32'h0F);
    rd(ADDR_RMI, 32'h07);
    pulse(2);
    pulse(1);
    rd(ADDR_SVC, {16'h0, VEC_TRAP, 8'h90});
    bus(1'b1, ADDR_SVC, 32'h0);
    pulse(2);
    rd(ADDR_RMI, 32'h07);
    $display("test trap done");
    stop_test();
  end
endmodule : cpu_interrupt_and_serial_bit_unit_tb

`default_nettype wire
